// ===== src/cpma_pkg.sv
/*
 Package for the program memory access block: widths, vectors, stack depth,
 pointer layout and linear data-memory mapping constants.
 Assumes a single core clock and synchronous active-low reset.
*/
package cpma_pkg;
	localparam int PC_W = 15;
	localparam int WORD_W = 14;
	localparam int DATA_W = 8;
	localparam int PTR_W = 16;
	localparam int DADDR_W = 12;
	localparam int STACK_DEPTH = 16;
	localparam int SP_W = 4;
	localparam int PSEL_BIT = 15;
	localparam int NUM_INSTR = 49;
	localparam logic [PC_W-1:0] RESET_VECTOR = 15'h0000;
	localparam logic [PC_W-1:0] INT_VECTOR = 15'h0004;
	localparam logic [PC_W-1:0] MASK_SMALL = 15'h03FF;
	localparam logic [PC_W-1:0] MASK_LARGE = 15'h07FF;
	localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
	localparam logic [SP_W-1:0] SP_TOP = 4'hF;
	localparam logic [SP_W-1:0] SP_ONE = 4'h1;
	// Linear view of general purpose RAM: base and 80-byte bank slices
	localparam logic [PTR_W-1:0] LIN_BASE = 16'h2000;
	localparam logic [PTR_W-1:0] LIN_END = 16'h8000;
	localparam logic [PTR_W-1:0] LIN_SLICE = 16'h0050;
	localparam logic [6:0] GPR_OFFSET = 7'h20;
	localparam int BANK_W = 5;
	localparam int OFS_W = 7;

	typedef enum logic [1:0] {
		CPMA_OP_NONE,
		CPMA_OP_READ,
		CPMA_OP_WRITE
	} cpma_op_type;

	// Context copied on interrupt entry and restored on return
	typedef struct packed {
		logic [7:0] accum;
		logic [4:0] status;
		logic [4:0] bank;
		logic [6:0] pclath;
		logic [PTR_W-1:0] ptr0;
		logic [PTR_W-1:0] ptr1;
	} cpma_ctx_type;

	// Flow control requests from the decoder
	typedef struct packed {
		logic advance;
		logic jump;
		logic call;
		logic ret;
		logic irq_take;
		logic retfie;
		logic [PC_W-1:0] target;
	} cpma_flow_type;
endpackage : cpma_pkg

// ===== src/cpma_core.sv
/*
 Program counter, return stack, context shadows and file select pointers with
 program-memory read through the indirect ports.
 Assumes decoder strobes one cycle wide, synchronous program memory read data.
*/
// Function
// - Sixteen-entry, fifteen-bit hardware return stack.
// - Overflow/underflow set flags, optional software reset.
// - Interrupt saves context; return restores it.
// - Two 16-bit pointers reach all memory.
// - Program memory indirect read adds one cycle.
// - Linear view of general purpose RAM.
// - Fifteen-bit counter over 32K by 14 space.
// - Addresses wrap inside implemented program memory.
// - Reset vector zero, interrupt vector four.
// - Implemented size 1024 or 2048 words.
// - High byte bit 7 selects program memory.
// - Indirect read loads low eight bits.
// - Indirect writes to program memory ignored.
// - Decoder set holds exactly 49 instructions.
`timescale 1ns/1ps
`default_nettype none
module cpma_core #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Flow control from decoder
	input wire cpma_pkg::cpma_flow_type flow,
	input wire cpma_pkg::cpma_ctx_type ctx_live,
	output cpma_pkg::cpma_ctx_type ctx_restore,
	output logic ctx_restore_valid,
	// Stack reset enable and flags
	input wire logic stack_reset_enable,
	input wire logic flags_clear,
	output logic stack_overflow_flag,
	output logic stack_underflow_flag,
	output logic soft_reset,
	// Pointer writes
	input wire logic [1:0] ptr_wr,
	input wire logic [cpma_pkg::PTR_W-1:0] ptr_wdata,
	output logic [cpma_pkg::PTR_W-1:0] file_select_pointer [2],
	// Indirect data port access
	input wire cpma_pkg::cpma_op_type ind_op,
	input wire logic ind_sel,
	output logic ind_stall,
	output logic ind_done,
	output logic [cpma_pkg::DATA_W-1:0] ind_rdata,
	output logic dmem_access,
	output logic dmem_write,
	output logic [cpma_pkg::DADDR_W-1:0] dmem_addr,
	input wire logic [cpma_pkg::DATA_W-1:0] dmem_rdata,
	// Program memory
	output logic [cpma_pkg::PC_W-1:0] pc,
	output logic [cpma_pkg::PC_W-1:0] pmem_addr,
	input wire logic [cpma_pkg::WORD_W-1:0] pmem_rdata,
	// Decoder capacity
	output logic [5:0] instr_count
);
	localparam logic [cpma_pkg::PC_W-1:0] MASK =
		LARGE_VARIANT ? cpma_pkg::MASK_LARGE : cpma_pkg::MASK_SMALL;

	logic [cpma_pkg::PC_W-1:0] pc_q, pc_d;
	logic [cpma_pkg::PC_W-1:0] stack_q [cpma_pkg::STACK_DEPTH];
	logic [cpma_pkg::PC_W-1:0] stack_d [cpma_pkg::STACK_DEPTH];
	logic [cpma_pkg::SP_W:0] depth_q, depth_d;
	logic ovf_q, ovf_d, unf_q, unf_d, srst_q, srst_d;
	cpma_pkg::cpma_ctx_type shadow_q, shadow_d;
	logic rvalid_q, rvalid_d;
	logic [cpma_pkg::PTR_W-1:0] ptr_q [2];
	logic [cpma_pkg::PTR_W-1:0] ptr_d [2];
	logic pwait_q, pwait_d, done_q, done_d;
	logic [cpma_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic [cpma_pkg::PTR_W-1:0] sel_ptr, lin_off;
	logic [cpma_pkg::BANK_W-1:0] lin_bank;
	logic [cpma_pkg::OFS_W-1:0] lin_ofs;
	logic is_prog, push, pop;

	assign sel_ptr = ptr_q[ind_sel];
	assign is_prog = sel_ptr[cpma_pkg::PSEL_BIT];
	assign push = flow.call | flow.irq_take;
	assign pop = flow.ret | flow.retfie;

	// Linear region splits into 80-byte slices of each bank
	always_comb begin
		lin_off = sel_ptr - cpma_pkg::LIN_BASE;
		lin_bank = cpma_pkg::BANK_W'(lin_off / cpma_pkg::LIN_SLICE);
		lin_ofs = cpma_pkg::OFS_W'(lin_off % cpma_pkg::LIN_SLICE) + cpma_pkg::GPR_OFFSET;
	end

	// Program counter and return stack
	always_comb begin
		pc_d = pc_q;
		stack_d = stack_q;
		depth_d = depth_q;
		ovf_d = ovf_q;
		unf_d = unf_q;
		srst_d = 1'b0;
		if (flags_clear) begin
			ovf_d = 1'b0;
			unf_d = 1'b0;
		end
		if (flow.irq_take) begin
			pc_d = cpma_pkg::INT_VECTOR;
		end else if (pop) begin
			pc_d = stack_q[cpma_pkg::SP_W'(depth_q - 1'b1)] & MASK;
		end else if (flow.jump | flow.call) begin
			pc_d = flow.target & MASK;
		end else if (flow.advance && !ind_stall) begin
			pc_d = (pc_q + cpma_pkg::PC_ONE) & MASK;
		end
		if (push) begin
			if (depth_q == (cpma_pkg::SP_W+1)'(cpma_pkg::STACK_DEPTH)) begin
				ovf_d = 1'b1;
				srst_d = stack_reset_enable;
			end else begin
				stack_d[cpma_pkg::SP_W'(depth_q)] = flow.irq_take ? pc_q : (pc_q + cpma_pkg::PC_ONE) & MASK;
				depth_d = depth_q + 1'b1;
			end
		end else if (pop) begin
			if (depth_q == '0) begin
				unf_d = 1'b1;
				srst_d = stack_reset_enable;
			end else begin
				depth_d = depth_q - 1'b1;
			end
		end
		if (srst_q) begin
			pc_d = cpma_pkg::RESET_VECTOR;
			depth_d = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pc_q <= cpma_pkg::RESET_VECTOR;
			depth_q <= '0;
		end else begin
			pc_q <= pc_d;
			depth_q <= depth_d;
		end
		stack_q <= stack_d;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
			srst_q <= 1'b0;
		end else begin
			ovf_q <= ovf_d;
			unf_q <= unf_d;
			srst_q <= srst_d;
		end
	end

	// Context shadows
	always_comb begin
		shadow_d = shadow_q;
		rvalid_d = 1'b0;
		if (flow.irq_take) begin
			shadow_d = ctx_live;
		end else if (flow.retfie) begin
			rvalid_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shadow_q <= '0;
			rvalid_q <= 1'b0;
		end else begin
			shadow_q <= shadow_d;
			rvalid_q <= rvalid_d;
		end
	end

	// Pointers and indirect access
	always_comb begin
		ptr_d = ptr_q;
		pwait_d = 1'b0;
		done_d = 1'b0;
		rdata_d = rdata_q;
		for (int i = 0; i < 2; i++) begin
			if (ptr_wr[i]) begin
				ptr_d[i] = ptr_wdata;
			end
		end
		if (rvalid_q) begin
			ptr_d[0] = shadow_q.ptr0;
			ptr_d[1] = shadow_q.ptr1;
		end
		if (ind_op == cpma_pkg::CPMA_OP_READ && is_prog) begin
			if (!pwait_q) begin
				pwait_d = 1'b1;
			end else begin
				rdata_d = pmem_rdata[cpma_pkg::DATA_W-1:0];
				done_d = 1'b1;
			end
		end else if (ind_op == cpma_pkg::CPMA_OP_READ) begin
			rdata_d = dmem_rdata;
			done_d = 1'b1;
		end else if (ind_op == cpma_pkg::CPMA_OP_WRITE) begin
			done_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ptr_q[0] <= '0;
			ptr_q[1] <= '0;
			pwait_q <= 1'b0;
			done_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			ptr_q <= ptr_d;
			pwait_q <= pwait_d;
			done_q <= done_d;
			rdata_q <= rdata_d;
		end
	end

	always_comb begin
		dmem_access = (ind_op != cpma_pkg::CPMA_OP_NONE) && !is_prog;
		dmem_write = (ind_op == cpma_pkg::CPMA_OP_WRITE) && !is_prog;
		if (sel_ptr >= cpma_pkg::LIN_BASE && sel_ptr < cpma_pkg::LIN_END) begin
			dmem_addr = {lin_bank, lin_ofs};
		end else begin
			dmem_addr = sel_ptr[cpma_pkg::DADDR_W-1:0];
		end
		if (ind_op == cpma_pkg::CPMA_OP_READ && is_prog) begin
			pmem_addr = sel_ptr[cpma_pkg::PC_W-1:0] & MASK;
		end else begin
			pmem_addr = pc_q;
		end
	end

	assign ind_stall = (ind_op == cpma_pkg::CPMA_OP_READ) && is_prog && !pwait_q;
	assign ind_done = done_q;
	assign ind_rdata = rdata_q;
	assign pc = pc_q;
	assign file_select_pointer = ptr_q;
	assign ctx_restore = shadow_q;
	assign ctx_restore_valid = rvalid_q;
	assign stack_overflow_flag = ovf_q;
	assign stack_underflow_flag = unf_q;
	assign soft_reset = srst_q;
	assign instr_count = 6'(cpma_pkg::NUM_INSTR);
endmodule : cpma_core
`default_nettype wire

// ===== testbench/cpma_mem_model.sv
/*
 Program flash and data RAM read data, computed from the address, seen by the access block.
 Assumes same-cycle reads; the flash has no write path.
*/
`timescale 1ns/1ps
`default_nettype none
module cpma_mem_model (
	// Addresses
	input wire logic [cpma_pkg::PC_W-1:0] pmem_addr,
	input wire logic [cpma_pkg::DADDR_W-1:0] dmem_addr,
	// Read data
	output logic [cpma_pkg::WORD_W-1:0] pmem_rdata,
	output logic [cpma_pkg::DATA_W-1:0] dmem_rdata
);
	// Word is the inverted address; its low byte repeats every 256 addresses
	assign pmem_rdata = ~pmem_addr[13:0];
	assign dmem_rdata = dmem_addr[7:0] ^ 8'h5A;
endmodule : cpma_mem_model
`default_nettype wire

// ===== testbench/cpma_core_sva.sv
/*
 Checker on the ports of cpma_core.
 Assumes it is bound to every cpma_core instance.
*/
`timescale 1ns/1ps
`default_nettype none
module cpma_core_chk #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	// Watched ports
	input wire logic clk,
	input wire logic rst_n,
	input wire cpma_pkg::cpma_flow_type flow,
	input wire cpma_pkg::cpma_op_type ind_op,
	input wire logic ind_sel,
	input wire logic ind_stall,
	input wire logic ind_done,
	input wire logic dmem_write,
	input wire logic soft_reset,
	input wire logic stack_overflow_flag,
	input wire logic stack_underflow_flag,
	input wire logic ctx_restore_valid,
	input wire logic [cpma_pkg::PTR_W-1:0] file_select_pointer [2],
	input wire logic [cpma_pkg::PC_W-1:0] pc,
	input wire logic [cpma_pkg::PC_W-1:0] pmem_addr,
	input wire logic [5:0] instr_count
);
	localparam logic [14:0] MASK = LARGE_VARIANT ? cpma_pkg::MASK_LARGE : cpma_pkg::MASK_SMALL;
	logic [15:0] ptr;
	assign ptr = file_select_pointer[ind_sel];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_prog_start;
		ind_stall;
	endsequence
	sequence s_data_start;
		ind_op == cpma_pkg::CPMA_OP_READ && !ptr[15] && $past(ind_op) == cpma_pkg::CPMA_OP_NONE;
	endsequence
	a_reset_vector: assert property ($rose(rst_n) |-> pc == cpma_pkg::RESET_VECTOR)
		else $error("pc not at reset vector");
	a_irq_vector: assert property (flow.irq_take && !soft_reset |=> pc == cpma_pkg::INT_VECTOR)
		else $error("pc not at interrupt vector");
	a_addr_wrap: assert property (pc <= MASK && pmem_addr <= MASK)
		else $error("address outside implemented memory");
	a_prog_extra: assert property (s_prog_start |=> !ind_stall && !ind_done ##1 ind_done)
		else $error("program read latency wrong");
	a_prog_addr: assert property (s_prog_start |=> pmem_addr == (ptr[14:0] & MASK))
		else $error("program read address wrong");
	a_prog_select: assert property (ind_stall |-> ptr[15] && ind_op == cpma_pkg::CPMA_OP_READ)
		else $error("stall without program select");
	a_data_quick: assert property (s_data_start |=> ind_done)
		else $error("data read latency wrong");
	a_no_pwrite: assert property (ind_op == cpma_pkg::CPMA_OP_WRITE && ptr[15] |-> !dmem_write)
		else $error("write reached memory");
	a_instr_set: assert property (instr_count == cpma_pkg::NUM_INSTR)
		else $error("instruction count wrong");
	a_soft_cause: assert property (soft_reset |-> (stack_overflow_flag || stack_underflow_flag) ##1 pc == cpma_pkg::RESET_VECTOR)
		else $error("soft reset without stack fault");
	a_ctx_return: assert property (flow.retfie |=> ctx_restore_valid)
		else $error("context not restored");
endmodule : cpma_core_chk
bind cpma_core cpma_core_chk #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (.*);
`default_nettype wire

// ===== testbench/cpma_core_bench.sv
/*
 Self-checking bench for cpma_core.
 Assumes the memory model answers in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module cpma_core_bench;
	logic clk = 1'b0, rst_n = 1'b0, stack_reset_enable = 1'b0, flags_clear = 1'b0, ind_sel = 1'b0;
	cpma_pkg::cpma_flow_type flow = '0;
	cpma_pkg::cpma_ctx_type ctx_live = '0, ctx_restore;
	cpma_pkg::cpma_op_type ind_op = cpma_pkg::CPMA_OP_NONE;
	logic ctx_restore_valid, stack_overflow_flag, stack_underflow_flag, soft_reset;
	logic ind_stall, ind_done, dmem_access, dmem_write;
	logic [1:0] ptr_wr = '0;
	logic [15:0] ptr_wdata = '0;
	logic [15:0] file_select_pointer [2];
	logic [7:0] ind_rdata, dmem_rdata;
	logic [11:0] dmem_addr;
	logic [14:0] pc, pmem_addr;
	logic [13:0] pmem_rdata;
	logic [5:0] instr_count;
	int n_mismatch = 0, checks = 0, cyc = 0;
	cpma_core u_dut (.*);
	cpma_mem_model u_mem (.*);
	always #2 clk = ~clk;
	task automatic report_and_stop;
		if (n_mismatch == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// Flow pulse: advance, jump, call, ret, irq, retfie
	task automatic fl(input logic [5:0] m, input logic [14:0] t);
		@(posedge clk) flow <= {m, t};
		@(posedge clk) flow <= '0;
		#1;
	endtask : fl
	task automatic ptr(input int s, input logic [15:0] v);
		@(posedge clk) begin ptr_wr <= 2'b01 << s; ptr_wdata <= v; end
		@(posedge clk) ptr_wr <= '0;
		#1 `CHK(file_select_pointer[s], v);
	endtask : ptr
	task automatic ind(input cpma_pkg::cpma_op_type op, input logic s, input int lat, input logic pr,
		input logic da, input logic dw);
		@(posedge clk) begin ind_op <= op; ind_sel <= s; end
		#1 `CHK(ind_stall, pr);
		`CHK(dmem_access, da);
		`CHK(dmem_write, dw);
		repeat (lat) @(posedge clk);
		ind_op <= cpma_pkg::CPMA_OP_NONE;
		#1 `CHK(ind_done, 1'b1);
	endtask : ind
	task automatic t_wrap;
		`CHK(pc, 15'h0000);
		`CHK(instr_count, 6'h31);
		fl(6'h10, 15'h7FFF);
		`CHK(pc, 15'h07FF);
		fl(6'h20, 15'h0000);
		`CHK(pc, 15'h0000);
	endtask : t_wrap
	task automatic t_stack;
		fl(6'h10, 15'h0123);
		fl(6'h08, 15'h0200);
		fl(6'h04, 15'h0000);
		`CHK(pc, 15'h0124);
		@(posedge clk) stack_reset_enable <= 1'b1;
		repeat (16) fl(6'h08, 15'h0300);
		`CHK(stack_overflow_flag, 1'b0);
		fl(6'h08, 15'h0300);
		`CHK(stack_overflow_flag, 1'b1);
		`CHK(soft_reset, 1'b1);
		@(posedge clk) begin stack_reset_enable <= 1'b0; flags_clear <= 1'b1; end
		#1 `CHK(pc, 15'h0000);
		`CHK(soft_reset, 1'b0);
		@(posedge clk) flags_clear <= 1'b0;
		fl(6'h04, 15'h0000);
		`CHK(stack_underflow_flag, 1'b1);
		`CHK(stack_overflow_flag, 1'b0);
		@(posedge clk) #1 `CHK(soft_reset, 1'b0);
	endtask : t_stack
	task automatic t_irq;
		fl(6'h10, 15'h0155);
		@(posedge clk) ctx_live <= {8'hA5, 5'h15, 5'h0A, 7'h3C, 32'h12345678};
		fl(6'h02, 15'h0000);
		`CHK(pc, 15'h0004);
		@(posedge clk) ctx_live <= '0;
		fl(6'h01, 15'h0000);
		`CHK(ctx_restore, {8'hA5, 5'h15, 5'h0A, 7'h3C, 32'h12345678});
		`CHK(pc, 15'h0155);
		`CHK(ctx_restore_valid, 1'b1);
		@(posedge clk) #1 `CHK(file_select_pointer[0], 16'h1234);
		`CHK(file_select_pointer[1], 16'h5678);
		`CHK(ctx_restore_valid, 1'b0);
	endtask : t_irq
	task automatic t_ind;
		ptr(0, 16'h9C05);
		ptr(1, 16'h2051);
		ind(cpma_pkg::CPMA_OP_READ, 1'b0, 2, 1'b1, 1'b0, 1'b0);
		`CHK(ind_rdata, 8'hFA);
		ind(cpma_pkg::CPMA_OP_READ, 1'b1, 1, 1'b0, 1'b1, 1'b0);
		`CHK(ind_rdata, 8'hFB);
		ind(cpma_pkg::CPMA_OP_WRITE, 1'b0, 1, 1'b0, 1'b0, 1'b0);
		ind(cpma_pkg::CPMA_OP_WRITE, 1'b1, 1, 1'b0, 1'b1, 1'b1);
	endtask : t_ind
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		#1 t_wrap();
		t_stack();
		t_irq();
		t_ind();
		report_and_stop();
	end
endmodule : cpma_core_bench
`default_nettype wire
